// ### sip_pkg.sv
// constants and register map of the sticky interrupt pending status block
package sip_pkg;
  localparam int          ADDR_W       = 9;
  localparam int          DATA_W       = 8;
  localparam int          NUM_REF      = 10;
  localparam int          NUM_PLL      = 4;
  localparam int          NUM_REF_LOW  = 8;
  localparam int          NUM_FLAGS    = NUM_REF + NUM_PLL;
  // register offsets
  localparam logic [8:0]  OFS_HOLD     = 9'h180;
  localparam logic [8:0]  OFS_REF_LOW  = 9'h182;
  localparam logic [8:0]  OFS_REF_HIGH = 9'h183;
  localparam logic [8:0]  OFS_PLL      = 9'h184;
  // reset values and fills
  localparam logic [7:0]  RST_HOLD     = 8'h00;
  localparam logic [7:0]  RST_FLAGS    = 8'h00;
  localparam logic [7:0]  READ_ZERO    = 8'h00;
  // field positions inside the flag vector
  localparam int          POS_REF_HIGH = NUM_REF_LOW;
  localparam int          POS_PLL      = NUM_REF;
  localparam int          W_REF_HIGH   = NUM_REF - NUM_REF_LOW;
endpackage

// ### sip_sticky_if.sv
// carrier between the register front end and the sticky flag bank
`timescale 1ns/10ps
interface sip_sticky_if #(parameter int W = 14);
  logic [W-1:0] evt;
  logic [W-1:0] clr;
  logic         hold;
  logic [W-1:0] flags;
  modport ctrl (output evt, output clr, output hold, input flags);
  modport bank (input evt, input clr, input hold, output flags);
endinterface

// ### sip_sticky_bank.sv
// bank of sticky pending flags with write-one-to-clear and update hold
`timescale 1ns/10ps
module sip_sticky_bank #(
  parameter int W = 14
) (
  input  wire logic clk,
  input  wire logic rst_n,
  sip_sticky_if.bank sb
);
  logic [W-1:0] flags_r;
  logic [W-1:0] flagsNxt;
  logic [W-1:0] kept;

  // clear first, then set unless the hold blocks updates
  assign kept     = flags_r & ~sb.clr;
  assign flagsNxt = sb.hold ? kept : (kept | sb.evt);
  assign sb.flags = flags_r;

  // flag storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flagsNxt;
    end
  end

  chk_hold_blocks_set: assert property (@(posedge clk) disable iff (!rst_n)
    sb.hold |=> ((flags_r & ~$past(flags_r)) == '0))
    else $error("sticky flag set while hold active");
  chk_event_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (!sb.hold && (sb.evt != '0)) |=> ((flags_r & $past(sb.evt)) == $past(sb.evt)))
    else $error("event did not set its flag");
  chk_clear_one_only: assert property (@(posedge clk) disable iff (!rst_n)
    (sb.evt == '0) |=> (flags_r == ($past(flags_r) & ~$past(sb.clr))))
    else $error("clear touched the wrong flags");
endmodule // sip_sticky_bank

// ### sip_pending_status.sv
// sticky interrupt pending status registers with host update hold
// Contract
// - non-zero hold register stops all hardware updates of the sticky flags.
// - pending flags of references seven to zero sit in bits seven..zero.
// - references nine and eight in bits one, zero; upper bits read zero.
// - pll zero to three pending in bits zero to three; upper bits zero.
`timescale 1ns/10ps
module sip_pending_status #(
  parameter int NREF = sip_pkg::NUM_REF,
  parameter int NPLL = sip_pkg::NUM_PLL
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [sip_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic                        regWrEn,
  input  wire logic [sip_pkg::DATA_W-1:0]  regWrData,
  input  wire logic                        regRdEn,
  output logic      [sip_pkg::DATA_W-1:0]  regRdData,
  output logic                             regRdValid,
  input  wire logic [NREF-1:0]             refEvent,
  input  wire logic [NPLL-1:0]             pllEvent,
  output logic      [NREF-1:0]             refPending,
  output logic      [NPLL-1:0]             pllPending,
  output logic                             holdActive
);
  localparam int NF = NREF + NPLL;

  // register state
  logic [sip_pkg::DATA_W-1:0] hold_r;
  logic [sip_pkg::DATA_W-1:0] holdNxt;
  logic [sip_pkg::DATA_W-1:0] rdData_r;
  logic [sip_pkg::DATA_W-1:0] rdDataNxt;
  logic                       rdValid_r;
  logic                       holdOn_r;
  logic [NF-1:0]              flagCopy_r;

  sip_sticky_if #(.W(NF)) stk ();

  sip_sticky_bank #(.W(NF)) u_bank (
    .clk   (clk),
    .rst_n (rst_n),
    .sb    (stk.bank)
  );

  // one-hot address decode
  function automatic logic hit(input logic [sip_pkg::ADDR_W-1:0] a, input logic [sip_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // decode of the four mapped registers
  wire selHold    = hit(regAddr, sip_pkg::OFS_HOLD);
  wire selRefLow  = hit(regAddr, sip_pkg::OFS_REF_LOW);
  wire selRefHigh = hit(regAddr, sip_pkg::OFS_REF_HIGH);
  wire selPll     = hit(regAddr, sip_pkg::OFS_PLL);

  // field slices of the flag vector
  wire [sip_pkg::NUM_REF_LOW-1:0] refLowFlags  = stk.flags[sip_pkg::NUM_REF_LOW-1:0];
  wire [sip_pkg::W_REF_HIGH-1:0]  refHighFlags = stk.flags[sip_pkg::POS_REF_HIGH +: sip_pkg::W_REF_HIGH];
  wire [NPLL-1:0]                 pllFlags     = stk.flags[sip_pkg::POS_PLL +: NPLL];

  // read views with reserved bits held at zero
  wire [sip_pkg::DATA_W-1:0] viewRefLow  = refLowFlags;
  wire [sip_pkg::DATA_W-1:0] viewRefHigh = {{(sip_pkg::DATA_W-sip_pkg::W_REF_HIGH){1'b0}}, refHighFlags};
  wire [sip_pkg::DATA_W-1:0] viewPll     = {{(sip_pkg::DATA_W-NPLL){1'b0}}, pllFlags};

  // write-one-to-clear masks; zero bits and reserved bits do nothing
  wire wrRefLow  = regWrEn && selRefLow;
  wire wrRefHigh = regWrEn && selRefHigh;
  wire wrPll     = regWrEn && selPll;
  wire [sip_pkg::NUM_REF_LOW-1:0] clrRefLow  = wrRefLow ? regWrData[sip_pkg::NUM_REF_LOW-1:0] : '0;
  wire [sip_pkg::W_REF_HIGH-1:0]  clrRefHigh = wrRefHigh ? regWrData[sip_pkg::W_REF_HIGH-1:0] : '0;
  wire [NPLL-1:0]                 clrPll     = wrPll ? regWrData[NPLL-1:0] : '0;

  // hand the events, clears and hold to the bank
  assign stk.evt  = {pllEvent, refEvent};
  assign stk.clr  = {clrPll, clrRefHigh, clrRefLow};
  assign stk.hold = (hold_r != sip_pkg::RST_HOLD);

  // hold register next value
  assign holdNxt = (regWrEn && selHold) ? regWrData : hold_r;

  // registered read mux; unmapped offsets read zero
  always_comb begin
    rdDataNxt = sip_pkg::READ_ZERO;
    if (regRdEn) begin
      if (selHold) begin
        rdDataNxt = hold_r;
      end else if (selRefLow) begin
        rdDataNxt = viewRefLow;
      end else if (selRefHigh) begin
        rdDataNxt = viewRefHigh;
      end else if (selPll) begin
        rdDataNxt = viewPll;
      end else begin
        rdDataNxt = sip_pkg::READ_ZERO;
      end
    end
  end

  // hold register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_r <= sip_pkg::RST_HOLD;
    end else begin
      hold_r <= holdNxt;
    end
  end

  // read answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_r  <= sip_pkg::READ_ZERO;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r  <= rdDataNxt;
      rdValid_r <= regRdEn;
    end
  end

  // status outputs, copied from the bank flags and the hold one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flagCopy_r <= '0;
      holdOn_r   <= 1'b0;
    end else begin
      flagCopy_r <= stk.flags;
      holdOn_r   <= stk.hold;
    end
  end

  assign regRdData  = rdData_r;
  assign regRdValid = rdValid_r;
  assign refPending = flagCopy_r[NREF-1:0];
  assign pllPending = flagCopy_r[NF-1:NREF];
  assign holdActive = holdOn_r;

  // a non-zero hold freezes every flag against new events
  chk_hold_freezes_flags: assert property (@(posedge clk) disable iff (!rst_n)
    ((hold_r != sip_pkg::RST_HOLD) && !regWrEn) |=> (stk.flags == $past(stk.flags)))
    else $error("sticky flags changed while held without a host write");

  // low reference read returns the flags of the request cycle
  chk_ref_low_read: assert property (@(posedge clk) disable iff (!rst_n)
    (regRdEn && selRefLow) |=> (regRdValid && regRdData == $past(viewRefLow)))
    else $error("reference low read does not match flags");

  // a reference event with the hold open shows as pending two cycles on
  chk_ref_event_pending: assert property (@(posedge clk) disable iff (!rst_n)
    (refEvent[0] && hold_r == sip_pkg::RST_HOLD) |-> ##2 refPending[0])
    else $error("reference event not shown as pending");

  // upper reserved bits of the high reference register read zero
  chk_ref_high_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (regRdEn && selRefHigh) |=> (regRdData[sip_pkg::DATA_W-1:sip_pkg::W_REF_HIGH] == '0
      && regRdData[sip_pkg::W_REF_HIGH-1:0] == $past(refHighFlags)))
    else $error("reference high read wrong or reserved bits set");

  // pll register reads the pll flags in the low nibble only
  chk_pll_read_view: assert property (@(posedge clk) disable iff (!rst_n)
    (regRdEn && selPll) |=> (regRdData[sip_pkg::DATA_W-1:NPLL] == '0
      && regRdData[NPLL-1:0] == $past(pllFlags)))
    else $error("pll read wrong or reserved bits set");

  // writing one clears a pll flag when no event arrives with it
  chk_pll_write_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (wrPll && regWrData[0] && !pllEvent[0]) |=> !pllFlags[0] ##1 !pllPending[0])
    else $error("pll flag not cleared by write of one");

  // writing zero leaves a set flag alone
  chk_zero_write_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    (wrRefLow && !regWrData[0] && refLowFlags[0]) |=> refLowFlags[0])
    else $error("write of zero cleared a reference flag");

  // an event in the clearing cycle wins over the clear
  chk_set_beats_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (wrRefLow && regWrData[1] && refEvent[1] && hold_r == sip_pkg::RST_HOLD) |=> refLowFlags[1])
    else $error("event lost against a simultaneous clear");

  // unmapped offsets answer zero
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (regRdEn && !(selHold || selRefLow || selRefHigh || selPll)) |=> (regRdValid && regRdData == '0))
    else $error("unmapped read returned non-zero");

  // hold output follows the hold register after one cycle
  chk_hold_output: assert property (@(posedge clk) disable iff (!rst_n)
    (regWrEn && selHold && regWrData != sip_pkg::RST_HOLD) |-> ##2 holdActive)
    else $error("hold status not shown after non-zero write");

  // writing zero to the hold register drops the hold status two cycles on
  chk_hold_release_opens: assert property (@(posedge clk) disable iff (!rst_n)
    (regWrEn && selHold && regWrData == sip_pkg::RST_HOLD) |-> ##2 !holdActive)
    else $error("hold status still shown after zero write");

  // hold register reads back as written
  chk_hold_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    (regRdEn && selHold) |=> (regRdValid && regRdData == $past(hold_r)))
    else $error("hold register read back wrong");

  // an event under hold leaves a clear flag clear, host write or not
  chk_hold_drops_event: assert property (@(posedge clk) disable iff (!rst_n)
    ((hold_r != sip_pkg::RST_HOLD) && refEvent[2] && !refLowFlags[2]) |=> !refLowFlags[2])
    else $error("event set a flag while hold active");

  // no read request, no answer and a zero data bus
  chk_idle_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !regRdEn |=> (!regRdValid && regRdData == sip_pkg::READ_ZERO))
    else $error("read answer without a read request");

  // a pll event with the hold open shows as pending two cycles on
  chk_pll_event_pending: assert property (@(posedge clk) disable iff (!rst_n)
    (pllEvent[0] && hold_r == sip_pkg::RST_HOLD) |-> ##2 pllPending[0])
    else $error("pll event not shown as pending");

  // the top reference event lands in the high register
  chk_ref_high_pending: assert property (@(posedge clk) disable iff (!rst_n)
    (refEvent[NREF-1] && hold_r == sip_pkg::RST_HOLD) |-> ##2 refPending[NREF-1])
    else $error("top reference event not shown as pending");

  // writing one clears a high reference flag when no event arrives with it
  chk_ref_high_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (wrRefHigh && regWrData[0] && !refEvent[sip_pkg::POS_REF_HIGH]) |=> !refHighFlags[0])
    else $error("high reference flag not cleared by write of one");

  // ones in reserved bits only clear nothing
  chk_reserved_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (wrRefHigh && regWrData[sip_pkg::W_REF_HIGH-1:0] == '0) |=> ((~refHighFlags & $past(refHighFlags)) == '0))
    else $error("reserved bit write cleared a flag");
endmodule // sip_pending_status

// ### sip_host_model.sv
// host processor model driving the register port of the status block
`timescale 1ns/10ps
module sip_host_model (
  input  wire logic       clk,
  output logic      [8:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  output logic            regRdEn
);
  // idle bus at time zero
  initial begin
    regAddr   = 9'h000;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
    regRdEn   = 1'b0;
  end
  // one write cycle; absolute offsets, page three taken as selected
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge clk);
    regWrEn   = 1'b0;
    regWrData = ~d;  // released data must not be trusted
  endtask
  // one read cycle
  task automatic rd(input logic [8:0] a);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
  endtask
endmodule // sip_host_model

// ### sticky_irq_pending_status_tb.sv
// self-checking bench of the sticky interrupt pending status block
`timescale 1ns/10ps
module sticky_irq_pending_status_tb;
  logic        clk, rst_n, regWrEn, regRdEn, regRdValid, holdActive;
  logic [8:0]  regAddr;
  logic [7:0]  regWrData, regRdData, holdM;
  logic [9:0]  refEvent, refPending, refM;
  logic [3:0]  pllEvent, pllPending, pllM;
  logic [15:0] seed;
  logic [7:0]  expQ[$];
  int          errors, checks_done;

  sip_pending_status dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .refEvent(refEvent), .pllEvent(pllEvent), .refPending(refPending), .pllPending(pllPending),
    .holdActive(holdActive));
  sip_host_model host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // note expected value, then read
  task automatic rdExp(input logic [8:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask

  // write and track the flag model; ones clear, zeros keep
  task automatic wrM(input logic [8:0] a, input logic [7:0] d);
    host.wr(a, d);
    case (a)
      sip_pkg::OFS_HOLD:     holdM = d;
      sip_pkg::OFS_REF_LOW:  refM[7:0] &= ~d;
      sip_pkg::OFS_REF_HIGH: refM[9:8] &= ~d[1:0];
      sip_pkg::OFS_PLL:      pllM &= ~d[3:0];
      default: ;
    endcase
  endtask

  // one cycle of events; dropped while hold is non-zero
  task automatic pulse(input logic [13:0] v);
    @(negedge clk);
    refEvent = v[9:0];
    pllEvent = v[13:10];
    if (holdM == 8'h00) begin
      refM |= v[9:0];
      pllM |= v[13:10];
    end
    @(negedge clk);
    refEvent = 10'h000;
    pllEvent = 4'h0;
  endtask

  task automatic readAll();
    rdExp(sip_pkg::OFS_REF_LOW, refM[7:0]);
    rdExp(sip_pkg::OFS_REF_HIGH, {6'h00, refM[9:8]});
    rdExp(sip_pkg::OFS_PLL, {4'h0, pllM});
    check({2'b00, pllPending, refPending}, {2'b00, pllM, refM});
  endtask

  // read monitor: oldest note against each answer
  always @(negedge clk) begin
    if (regRdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        check({8'h00, regRdData}, 16'hFFFF);
      end else begin
        check({8'h00, regRdData}, {8'h00, expQ.pop_front()});
      end
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    refEvent = 10'h000;
    pllEvent = 4'h0;
    refM = 10'h000;
    pllM = 4'h0;
    holdM = 8'h00;
    seed = 16'h0017;
    errors = 0;
    checks_done = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rdExp(sip_pkg::OFS_HOLD, sip_pkg::RST_HOLD);
    readAll();
    wrM(9'h181, 8'hFF);
    rdExp(9'h181, sip_pkg::READ_ZERO);
    // random events then random clears, reserved bits included
    for (int i = 0; i < 12; i++) begin
      seed = lfsrNext(seed);
      pulse(seed[13:0]);
      readAll();
      wrM(sip_pkg::OFS_REF_LOW, 8'h00);
      seed = lfsrNext(seed);
      wrM(sip_pkg::OFS_REF_LOW, seed[7:0]);
      wrM(sip_pkg::OFS_REF_HIGH, seed[15:8]);
      wrM(sip_pkg::OFS_PLL, seed[11:4]);
      readAll();
    end
    // hold, clear, release, read back
    wrM(sip_pkg::OFS_HOLD, 8'h80);
    rdExp(sip_pkg::OFS_HOLD, 8'h80);
    check({15'h0000, holdActive}, 16'h0001);
    pulse(14'h3FFF);
    readAll();
    wrM(sip_pkg::OFS_REF_LOW, 8'hA5);
    pulse(14'h3FFF);
    wrM(sip_pkg::OFS_HOLD, 8'h00);
    readAll();
    check({15'h0000, holdActive}, 16'h0000);
    pulse(14'h3FFF);
    readAll();
    // zero write keeps flags; a clear meeting its own event loses
    wrM(sip_pkg::OFS_REF_LOW, 8'h00);
    fork
      wrM(sip_pkg::OFS_REF_LOW, 8'h02);
      pulse(14'h0002);
    join
    refM[1] = 1'b1;  // set wins over the clear
    readAll();
    // reset in mid-run with the hold set and every flag pending
    wrM(sip_pkg::OFS_HOLD, 8'h5A);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    refM = 10'h000;
    pllM = 4'h0;
    holdM = sip_pkg::RST_HOLD;
    rdExp(sip_pkg::OFS_HOLD, sip_pkg::RST_HOLD);
    readAll();
    check({15'h0000, holdActive}, 16'h0000);
    repeat (3) @(negedge clk);
    check(16'(expQ.size()), 16'h0000);
    report_and_stop();
  end
endmodule // sticky_irq_pending_status_tb
